// *** rtl/tsp_pkg.sv ***
package tsp_pkg;

    // ======================================================================
    // clock rates and link timing
    // ======================================================================
    localparam int REF_PERIOD_NS     = 100;
    localparam int REF_CLK_HZ        = 10_000_000;
    // the link clock in the bench runs at 800 ns; the device-made clock uses it too
    localparam int LINK_CLK_HALF_NS  = 400;
    localparam int LINK_HALF_CYC     = LINK_CLK_HALF_NS / REF_PERIOD_NS;
    localparam logic [3:0] LINK_HALF_LAST = 4'(LINK_HALF_CYC - 1);

    // ======================================================================
    // tdm frame structure
    // ======================================================================
    localparam int TDM_BIT_RATE_KBPS = 2048;
    localparam int TDM_CHANNELS      = 32;
    localparam int CHAN_RATE_KBPS    = 64;
    localparam int FRAME_RATE_KHZ    = 8;
    localparam int BIT_CLOCK_KHZ     = 4096;
    localparam int CLK_PER_BIT       = BIT_CLOCK_KHZ / TDM_BIT_RATE_KBPS;
    localparam int FRAME_TICKS       = (TDM_BIT_RATE_KBPS / FRAME_RATE_KHZ) * CLK_PER_BIT;
    localparam logic [8:0] TICK_FIRST = 9'h000;
    localparam logic [8:0] TICK_LAST  = 9'(FRAME_TICKS - 1);
    // delayed pulse marks the boundary after the last slot this device uses
    localparam logic [8:0] DFP_TICK   = 9'h03f;
    localparam logic [4:0] LAST_USED_SLOT = 5'h03;
    localparam int SLOT_D  = 0;
    localparam int SLOT_C  = 1;

    // ======================================================================
    // mode detection and adaptive timing wait
    // ======================================================================
    localparam logic [4:0] NT_DETECT_SAT = 5'h10;
    localparam int ADAPT_WAIT_MS  = 100;
    localparam int ADAPT_WAIT_CYC = ADAPT_WAIT_MS * (REF_CLK_HZ / 1000);

    // ======================================================================
    // registers
    // ======================================================================
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int CTRL_DR     = 0;
    localparam int CTRL_AR     = 1;
    localparam int CTRL_STAR   = 2;
    localparam int CTRL_SLAVE  = 3;
    localparam int CTRL_TIMING = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam int ST_TE    = 0;
    localparam int ST_ADAPT = 1;
    localparam int ST_READY = 2;
    localparam int ST_IS0   = 3;
    localparam int ST_IS1   = 4;
    localparam int ST_OPEN  = 5;
    localparam int ST_SLAVE = 6;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0][7:0] ch;
    } tsp_slots_t;

    function automatic logic [4:0] tsp_slot_of(input logic [8:0] t);
        return t[8:4];
    endfunction : tsp_slot_of

    // tdm bytes go msb first, so bit cell k carries byte bit 7-k
    function automatic logic [2:0] tsp_bitpos_of(input logic [8:0] t);
        return ~t[3:1];
    endfunction : tsp_bitpos_of

endpackage : tsp_pkg

// *** rtl/tsp_tdm_port.sv ***
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - control bit four selects point-to-point or passive-bus wiring configuration.
// - nt fixed timing keeps recovery, filters and peak detect off, threshold fixed.
// - te or nt adaptive enables recovery, filters, peak-relative threshold.
// - star mode shares received 2B+D with all nts via star pin.
// - mode pin high plus slave bit: nt role with te frame and registers.
// - after reset an nt starts in fixed timing.
// - clearing the timing bit returns to fixed timing.
// - stream runs 2048 kbit/s as 32 channels of 64 kbit/s.
// - an 8 kHz frame pulse marks every frame boundary.
// - input data sampled on rising clock edge three quarters into cell.
// - output data launched on falling clock edge at cell start.
// - in te mode the device drives bit clock and frame pulse in phase.
// - only the first four channel slots of each frame are used.
// - a delayed frame pulse drives the next device of a daisy chain.
// - line-to-tdm data always passes regardless of activation state.
// - tdm-to-line data passes only once active (nt) or synchronised (te).
module tsp_tdm_port #(
    parameter int ADAPT_WAIT_CYCLES = tsp_pkg::ADAPT_WAIT_CYC
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // axi4-lite register slave
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // tdm timing pins
    input  wire logic              bit_clock_x2_io_i,
    output logic                   bit_clock_x2_io_o,
    output logic                   bit_clock_x2_io_oe,
    input  wire logic              frame_pulse_io_n_i,
    output logic                   frame_pulse_io_n_o,
    output logic                   frame_pulse_io_oe,
    output logic                   delayed_frame_pulse_out_n,
    input  wire logic              termination_mode_clock_select_pin,
    // tdm data and star pins
    input  wire logic              tdm_serial_in,
    output logic                   tdm_serial_out,
    output logic                   tdm_serial_out_oe,
    input  wire logic              star_i,
    output logic                   star_o,
    output logic                   star_oe,
    // activation machine
    input  wire logic              line_state_bit0,
    input  wire logic              line_state_bit1,
    output logic                   deactivation_request_bit,
    output logic                   activation_request_bit,
    // line-side slot data
    input  wire tsp_pkg::tsp_slots_t line_rx_slots,
    output tsp_pkg::tsp_slots_t    line_tx_slots,
    output logic                   line_tx_valid,
    // receiver front-end controls
    output logic                   clk_recovery_en,
    output logic                   rx_filter_en,
    output logic                   peak_detect_en,
    output logic                   threshold_adaptive,
    output logic                   passive_bus_config,
    output logic                   te_frame_format
);
    import tsp_pkg::*;

    // ======================================================================
    // pin synchronisers
    // ======================================================================
    logic clk_s1, clk_s2, fp_s1, fp_s2, din_s1, din_s2, star_s1, star_s2, pin_s1, pin_s2;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {clk_s1, clk_s2, din_s1, din_s2} <= 4'h0;
            // mode pin idles high so no te glitch follows reset
            {fp_s1, fp_s2, star_s1, star_s2, pin_s1, pin_s2} <= 6'h3f;
        end else begin
            clk_s1  <= bit_clock_x2_io_i;
            clk_s2  <= clk_s1;
            fp_s1   <= frame_pulse_io_n_i;
            fp_s2   <= fp_s1;
            din_s1  <= tdm_serial_in;
            din_s2  <= din_s1;
            star_s1 <= star_i;
            star_s2 <= star_s1;
            pin_s1  <= termination_mode_clock_select_pin;
            pin_s2  <= pin_s1;
        end
    end

    // ======================================================================
    // control register and mode
    // ======================================================================
    logic [4:0] ctrl;
    logic [4:0] pin_hi_cnt;
    logic       te_mode;
    logic       timing_bit;
    logic       adaptive;
    logic [19:0] adapt_cnt;
    logic       adapt_ready;
    logic       nt_slave;
    logic       tx_open;

    assign timing_bit = ctrl[CTRL_TIMING];
    assign adaptive   = !te_mode && timing_bit;
    assign nt_slave   = !te_mode && ctrl[CTRL_SLAVE];

    // mode pin
    // a clock on the pin keeps it from staying high, so it also reads as te
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_hi_cnt <= NT_DETECT_SAT;
            te_mode    <= 1'b0;
        end else begin
            if (!pin_s2)
                pin_hi_cnt <= 5'h00;
            else if (pin_hi_cnt != NT_DETECT_SAT)
                pin_hi_cnt <= pin_hi_cnt + 5'h01;
            te_mode <= (pin_hi_cnt != NT_DETECT_SAT);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            adapt_cnt   <= 20'h00000;
            adapt_ready <= 1'b0;
        end else if (!adaptive) begin
            adapt_cnt   <= 20'h00000;
            adapt_ready <= 1'b0;
        end else if (adapt_cnt != 20'(ADAPT_WAIT_CYCLES)) begin
            adapt_cnt   <= adapt_cnt + 20'h00001;
        end else begin
            adapt_ready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_recovery_en    <= 1'b0;
            rx_filter_en       <= 1'b0;
            peak_detect_en     <= 1'b0;
            threshold_adaptive <= 1'b0;
            passive_bus_config <= 1'b0;
            te_frame_format    <= 1'b0;
            deactivation_request_bit <= 1'b0;
            activation_request_bit   <= 1'b0;
        end else begin
            clk_recovery_en    <= te_mode || timing_bit;
            rx_filter_en       <= te_mode || timing_bit;
            peak_detect_en     <= te_mode || timing_bit;
            threshold_adaptive <= te_mode || timing_bit;
            passive_bus_config <= timing_bit;
            te_frame_format    <= te_mode || nt_slave;
            deactivation_request_bit <= ctrl[CTRL_DR];
            activation_request_bit   <= ctrl[CTRL_AR];
        end
    end

    // gate: nt waits for the active state, te for synchronisation
    assign tx_open = te_mode ? line_state_bit0 : (line_state_bit0 && line_state_bit1);

    // ======================================================================
    // link clock: sampled in nt, made here in te
    // ======================================================================
    logic [3:0] te_div;
    logic       te_clk, clk_now, clk_prev, le_rise, le_fall;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            te_div <= 4'h0;
            te_clk <= 1'b0;
        end else if (te_div == LINK_HALF_LAST) begin
            te_div <= 4'h0;
            te_clk <= !te_clk;
        end else begin
            te_div <= te_div + 4'h1;
        end
    end

    assign clk_now = te_mode ? te_clk : clk_s2;
    assign le_rise = clk_now && !clk_prev;
    assign le_fall = !clk_now && clk_prev;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            clk_prev <= 1'b0;
        else
            clk_prev <= clk_now;
    end

    // ======================================================================
    // frame counter: two clock periods per bit, 256 bits per frame
    // ======================================================================
    logic [8:0] tick, next_tick;
    logic       fp_seen;
    logic [4:0] slot, next_slot;

    assign next_tick = fp_seen ? TICK_FIRST : tick + 9'h001;
    assign slot      = tsp_slot_of(tick);
    assign next_slot = tsp_slot_of(next_tick);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick    <= TICK_LAST;
            fp_seen <= 1'b0;
        end else begin
            if (le_rise)
                fp_seen <= te_mode ? !frame_pulse_io_n_o : !fp_s2;
            if (le_fall)
                tick <= next_tick;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_clock_x2_io_o  <= 1'b0;
            bit_clock_x2_io_oe <= 1'b0;
            frame_pulse_io_n_o <= 1'b1;
            frame_pulse_io_oe  <= 1'b0;
            delayed_frame_pulse_out_n <= 1'b1;
        end else begin
            bit_clock_x2_io_o  <= te_clk;
            bit_clock_x2_io_oe <= te_mode;
            frame_pulse_io_oe  <= te_mode;
            if (le_fall) begin
                frame_pulse_io_n_o <= (next_tick != TICK_LAST);
                delayed_frame_pulse_out_n <= (next_tick != DFP_TICK);
            end
        end
    end

    // ======================================================================
    // serial data
    // ======================================================================
    tsp_slots_t in_slots, out_slots, star_slots;
    logic       star_slot;

    // star carries 2B+D only: the control slot stays local
    assign star_slot = ctrl[CTRL_STAR] && !te_mode && (next_slot != 5'(SLOT_C));

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_slots   <= '0;
            star_slots <= '0;
        end else if (le_rise && tick[0] && slot <= LAST_USED_SLOT) begin
            in_slots.ch[slot[1:0]][tsp_bitpos_of(tick)]   <= din_s2;
            star_slots.ch[slot[1:0]][tsp_bitpos_of(tick)] <= star_s2;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tdm_serial_out    <= 1'b1;
            tdm_serial_out_oe <= 1'b0;
            star_o            <= 1'b0;
            star_oe           <= 1'b0;
        end else if (le_fall) begin
            if (next_slot <= LAST_USED_SLOT) begin
                tdm_serial_out_oe <= 1'b1;
                if (!next_tick[0])
                    tdm_serial_out <= out_slots.ch[next_slot[1:0]][tsp_bitpos_of(next_tick)];
                star_oe <= star_slot && !line_rx_slots.ch[next_slot[1:0]][tsp_bitpos_of(next_tick)];
            end else begin
                tdm_serial_out_oe <= 1'b0;
                star_oe           <= 1'b0;
            end
        end
    end

    // frame-boundary transfers; star data lands one frame later on every nt alike
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_slots     <= '0;
            line_tx_slots <= '0;
            line_tx_valid <= 1'b0;
        end else begin
            line_tx_valid <= 1'b0;
            // load in the last tick so the launch at tick zero sees the new frame;
            // a frame cut short by a realigning pulse keeps the previous data
            if (le_rise && tick == TICK_LAST) begin
                out_slots <= line_rx_slots;
                if (ctrl[CTRL_STAR] && !te_mode) begin
                    out_slots <= star_slots;
                    out_slots.ch[SLOT_C] <= line_rx_slots.ch[SLOT_C];
                end
            end
            if (le_fall && next_tick == TICK_FIRST) begin
                if (tx_open) begin
                    line_tx_slots <= in_slots;
                    line_tx_valid <= 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // axi4-lite slave
    // ======================================================================
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_held, w_held;
    logic [31:0] status;

    assign status = {25'h0, nt_slave, tx_open, line_state_bit1, line_state_bit0,
                     adapt_ready, adaptive, te_mode};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            aw_held       <= 1'b0;
            aw_addr       <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            aw_held       <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_wready <= 1'b1;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
            w_held       <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl         <= CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (aw_held && w_held && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[11:2] == REG_CTRL[11:2]) ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr[11:2] == REG_CTRL[11:2] && w_strb[0])
                ctrl <= w_data[4:0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            unique case (s_axi_araddr[11:2])
                REG_CTRL[11:2]:   s_axi_rdata <= {27'h0, ctrl};
                REG_STATUS[11:2]: s_axi_rdata <= status;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ======================================================================
    // assertions
    // ======================================================================
    AST_WIRING_CFG: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ##1 passive_bus_config == $past(timing_bit))
        else $error("wiring configuration does not follow timing bit");
    AST_FIXED_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!te_mode && !timing_bit) |=> !clk_recovery_en && !peak_detect_en && !threshold_adaptive)
        else $error("fixed timing left front-end paths enabled");
    AST_ADAPT_ON: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (te_mode || timing_bit) |=> clk_recovery_en && rx_filter_en && threshold_adaptive)
        else $error("adaptive front-end paths not enabled");
    AST_TIMING_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(timing_bit) |-> !adaptive ##1 !clk_recovery_en || te_mode)
        else $error("clearing timing bit did not restore fixed timing");
    AST_SLOTS_ONLY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        tdm_serial_out_oe |-> slot <= LAST_USED_SLOT)
        else $error("serial output driven outside the first four slots");
    AST_LAUNCH_EDGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $changed(tdm_serial_out) |-> $past(le_fall) && !tick[0])
        else $error("serial output changed away from a cell start");
    AST_GATE_TX: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(line_tx_valid) |-> $past(tx_open) && tick == TICK_FIRST)
        else $error("tdm data released to line before activation");
    AST_DAISY_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !delayed_frame_pulse_out_n |-> tick == DFP_TICK)
        else $error("delayed frame pulse at the wrong point");
    AST_TE_DRIVES: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ##2 bit_clock_x2_io_oe == $past(te_mode, 1) && frame_pulse_io_oe == bit_clock_x2_io_oe)
        else $error("timing pin direction does not follow mode");
    AST_SETTLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(adapt_ready) |-> adaptive && adapt_cnt == 20'(ADAPT_WAIT_CYCLES))
        else $error("adaptive settle flag raised early");

endmodule : tsp_tdm_port

// *** bench/tsp_tdm_source.sv ***
`timescale 1ns/1ps
module tsp_tdm_source #(
    parameter logic [31:0] PAT = 32'h0
) (
    // system timing outputs
    output logic bclk,
    output logic fp_n,
    // serial data toward the port
    output logic dout
);
    // ======================================================================
    // free-running system timebase
    // ======================================================================
    int tick = 0;
    wire [8:0] nt = 9'(tick + 1);
    initial bclk = 1'h1;
    initial fp_n = 1'h1;
    initial dout = 1'h1;
    always #400 bclk = ~bclk;
    always @(negedge bclk) begin
        tick <= (tick + 1) % 512;
        fp_n <= (tick != 510);
        // data changes at cell start, three quarters of a cell before it is sampled
        dout <= PAT[{nt[5:4], ~nt[3:1]}];
    end
endmodule : tsp_tdm_source

// *** bench/tsp_tdm_port_bench.sv ***
`timescale 1ns/1ps
module tsp_tdm_port_bench;
    import tsp_pkg::*;
    logic ref_clk = 1'h0, reset_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic termination_mode_clock_select_pin = 1'h1, line_state_bit0 = 1'h0, line_state_bit1 = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, star_o;
    logic bit_clock_x2_io_o, bit_clock_x2_io_oe, frame_pulse_io_n_o, frame_pulse_io_oe, star_oe;
    logic delayed_frame_pulse_out_n, tdm_serial_out, tdm_serial_out_oe, line_tx_valid;
    logic deactivation_request_bit, activation_request_bit, clk_recovery_en, rx_filter_en;
    logic peak_detect_en, threshold_adaptive, passive_bus_config, te_frame_format;
    tsp_slots_t line_rx_slots = 32'hc35a_e781, line_tx_slots;
    localparam tsp_slots_t RX_PAT = 32'h5aa5_3c96;
    wire src_clk, src_fp, bit_clock_x2_io_i, frame_pulse_io_n_i, star_i, tdm_serial_in;
    int mismatches = 0, total_checks = 0;
    logic [31:0] rv;
    // star wire is pulled up while nobody pulls it low
    // a lone nt on the star wire, with the timing bit set only briefly in the timing test
    assign star_i = ~star_oe;
    assign bit_clock_x2_io_i = bit_clock_x2_io_oe ? bit_clock_x2_io_o : src_clk;
    assign frame_pulse_io_n_i = frame_pulse_io_oe ? frame_pulse_io_n_o : src_fp;
    tsp_tdm_port #(.ADAPT_WAIT_CYCLES(20)) u_tsp_tdm_port (.*);
    tsp_tdm_source #(.PAT(RX_PAT)) u_tsp_tdm_source (.bclk(src_clk), .fp_n(src_fp),
                                                     .dout(tdm_serial_in));
    always #50 ref_clk = ~ref_clk;
    // ======================================================================
    // checking and bus tasks
    // ======================================================================
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        fork
            begin do @(posedge ref_clk); while (!s_axi_awready); s_axi_awvalid <= 1'h0; end
            begin do @(posedge ref_clk); while (!s_axi_wready); s_axi_wvalid <= 1'h0; end
        join
        do @(posedge ref_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'h0;
        @(posedge ref_clk);
    endtask : rd
    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic t_timing();
        rd(REG_CTRL, RESP_OKAY);
        chk(rv, 32'h0);
        rd(12'h008, RESP_SLVERR);
        wr(REG_CTRL, 32'h1);
        wr(REG_CTRL, 32'h11);
        repeat (3) @(posedge ref_clk);
        chk({clk_recovery_en, rx_filter_en, peak_detect_en, threshold_adaptive,
             passive_bus_config}, 32'h1f);
        rd(REG_STATUS, RESP_OKAY);
        chk(rv[2:0], 32'h2);
        repeat (24) @(posedge ref_clk);
        rd(REG_STATUS, RESP_OKAY);
        chk(rv[2:0], 32'h6);
        wr(REG_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk({clk_recovery_en, rx_filter_en, peak_detect_en, threshold_adaptive,
             passive_bus_config}, 32'h0);
        chk(deactivation_request_bit, 32'h1);
        wr(REG_CTRL, 32'ha);
        chk({te_frame_format, activation_request_bit, deactivation_request_bit}, 32'h6);
        $display("timing test done");
    endtask : t_timing
    task automatic t_frame();
        int i;
        // start at a frame boundary, not part-way through the used slots
        do @(posedge ref_clk); while (tdm_serial_out_oe);
        do @(posedge ref_clk); while (!tdm_serial_out_oe);
        for (i = 0; i < 32; i++) begin
            repeat (8) @(posedge ref_clk);
            chk(tdm_serial_out, line_rx_slots.ch[i/8][7-i%8]);
            if (i < 31) repeat (8) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
        chk(delayed_frame_pulse_out_n, 32'h0);
        repeat (12) @(posedge ref_clk);
        chk(tdm_serial_out_oe, 32'h0);
        $display("frame test done");
    endtask : t_frame
    task automatic t_gate();
        rd(REG_STATUS, RESP_OKAY);
        chk(rv[ST_OPEN], 32'h0);
        line_state_bit0 <= 1'h1;
        line_state_bit1 <= 1'h1;
        rd(REG_STATUS, RESP_OKAY);
        chk(rv[ST_OPEN], 32'h1);
        do @(posedge ref_clk); while (!line_tx_valid);
        chk(line_tx_slots, RX_PAT);
        termination_mode_clock_select_pin <= 1'h0;
        line_state_bit1 <= 1'h0;
        repeat (8) @(posedge ref_clk);
        chk({bit_clock_x2_io_oe, frame_pulse_io_oe, te_frame_format, clk_recovery_en},
            32'hf);
        rd(REG_STATUS, RESP_OKAY);
        chk(rv[ST_OPEN], 32'h1);
        $display("gate and te test done");
    endtask : t_gate
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        results();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (20) @(posedge ref_clk);
        t_timing();
        t_frame();
        t_gate();
        results();
    end
endmodule : tsp_tdm_port_bench
